// file: rtl/hsc_connect_ctrl.sv
/*
  hot-swap connect sequencer and direction logic for a single-ended to
  differential two-wire bus buffer; drivers and comparators are outside.
  assumes pin levels and comparator flags are asynchronous, and that the
  controlling party changes enable only while the bus is idle.
*/
// Contract
// - during power-up keep all single-ended and differential pins undriven.
// - after supply is good wait the settle time, then sense the pairs.
// - termination valid when both minus below 0.9 and plus above 0.1.
// - connect when enabled and both plus lines stayed high for idle time.
// - connect when enabled, clock and data high, and stop was seen.
// - enable low never connects and isolates both buses.
// - disconnected status or power loss separates buses; sequence reruns.
// - each channel drives or receives, never both, chosen from activity.
// - with no traffic leave the pair released so plus rests above minus.
// - reversed pair pulls single-ended line low until idle polarity returns.
// - stop is data rising while clock is high.
// - enable is active high and reads high when undriven.
`timescale 1ns/1ps
`include "hsc_defs.svh"

module hsc_connect_ctrl
  import hsc_pkg::*;
#(
  parameter int SETTLE_CYCLES = `HSC_SETTLE_CYCLES,
  parameter int ARM_CYCLES    = `HSC_ARM_CYCLES,
  parameter int IDLE_CYCLES   = `HSC_IDLE_CYCLES
) (
  input  wire logic           i_clock,
  input  wire logic           i_srst,
  input  wire logic           i_power_good,
  input  wire logic           i_enable_level,
  input  wire logic           i_enable_driven,
  input  wire logic           i_scl,
  input  wire logic           i_sda,
  input  wire hsc_diff_pair_t i_diff_clock,
  input  wire hsc_diff_pair_t i_diff_data,
  input  wire logic [1:0]     i_minus_below_hi,
  input  wire logic [1:0]     i_plus_above_lo,
  output hsc_pin_drive_t      o_scl,
  output hsc_pin_drive_t      o_sda,
  output hsc_pin_drive_t      o_diff_clock_plus,
  output hsc_pin_drive_t      o_diff_clock_minus,
  output hsc_pin_drive_t      o_diff_data_plus,
  output hsc_pin_drive_t      o_diff_data_minus,
  output logic                o_armed,
  output logic                o_connected
);

  localparam int TW = `HSC_TIMER_WIDTH;
  localparam int IW = `HSC_IDLE_WIDTH;

  logic [`HSC_SYNC_WIDTH-1:0] sync_in;
  logic [`HSC_SYNC_WIDTH-1:0] sync_out;
  logic                       scl_s;
  logic                       sda_s;
  logic                       dcp_s;
  logic                       dcm_s;
  logic                       ddp_s;
  logic                       ddm_s;
  logic [1:0]                 minus_ok_s;
  logic [1:0]                 plus_ok_s;
  logic                       power_s;
  logic                       en_level_s;
  logic                       en_driven_s;
  logic                       enable;
  logic                       term_ok;
  hsc_state_t                 state_reg;
  hsc_state_t                 state_next;
  logic [TW-1:0]              timer_reg;
  logic [IW-1:0]              idle_reg;
  logic                       idle_done;
  logic                       stop_seen_reg;
  logic                       data_hi_reg;
  logic                       data_hi;
  logic                       clock_hi;
  logic                       conn_ok;
  hsc_dir_t                   dir_reg [2];
  logic [1:0]                 se_hi;
  logic [1:0]                 diff_rev;

  assign sync_in = {i_scl, i_sda, i_diff_clock.plus, i_diff_clock.minus,
                    i_diff_data.plus, i_diff_data.minus, i_minus_below_hi,
                    i_plus_above_lo, i_power_good, i_enable_level, i_enable_driven};

  hsc_sync #(
    .WIDTH (`HSC_SYNC_WIDTH)
  ) u_sync (
    .i_clock (i_clock),
    .i_srst  (i_srst),
    .i_async (sync_in),
    .o_sync  (sync_out)
  );

  assign {scl_s, sda_s, dcp_s, dcm_s, ddp_s, ddm_s, minus_ok_s, plus_ok_s,
          power_s, en_level_s, en_driven_s} = sync_out;

  // undriven enable pin reads high, as a pull-up would make it
  assign enable   = en_driven_s ? en_level_s : 1'b1;
  assign term_ok  = (&minus_ok_s) & (&plus_ok_s);
  assign data_hi  = ddp_s & ~ddm_s;
  assign clock_hi = dcp_s & ~dcm_s;
  assign se_hi    = {sda_s, scl_s};
  assign diff_rev = {ddm_s & ~ddp_s, dcm_s & ~dcp_s};
  assign idle_done = (idle_reg == IW'(IDLE_CYCLES));

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      HSC_ST_OFF: begin
        if (power_s) begin
          state_next = HSC_ST_SETTLE;
        end
      end
      HSC_ST_SETTLE: begin
        if (timer_reg == TW'(SETTLE_CYCLES - 1)) begin
          state_next = HSC_ST_TERM_CHECK;
        end
      end
      HSC_ST_TERM_CHECK: begin
        if (term_ok) begin
          state_next = HSC_ST_ARM_WAIT;
        end
      end
      HSC_ST_ARM_WAIT: begin
        if (!term_ok) begin
          state_next = HSC_ST_TERM_CHECK;
        end else if (timer_reg == TW'(ARM_CYCLES - 1)) begin
          state_next = HSC_ST_ARMED;
        end
      end
      HSC_ST_ARMED: begin
        if (!term_ok) begin
          state_next = HSC_ST_TERM_CHECK;
        end else if (enable && (idle_done || (stop_seen_reg && scl_s && sda_s))) begin
          state_next = HSC_ST_CONNECTED;
        end
      end
      HSC_ST_CONNECTED: begin
        if (!term_ok || !enable) begin
          state_next = HSC_ST_TERM_CHECK;
        end
      end
    endcase
    // power loss wins over everything and restarts the sequence
    if (!power_s) begin
      state_next = HSC_ST_OFF;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      state_reg <= HSC_ST_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  // one shared timer; restarts on every state change
  always_ff @(posedge i_clock) begin
    if (i_srst || state_next != state_reg) begin
      timer_reg <= `HSC_TIMER_RESET;
    end else if (state_reg == HSC_ST_SETTLE || state_reg == HSC_ST_ARM_WAIT) begin
      timer_reg <= timer_reg + TW'(1);
    end
  end

  // idle and stop detection only run once armed
  always_ff @(posedge i_clock) begin
    if (i_srst || state_reg != HSC_ST_ARMED || !(ddp_s && dcp_s)) begin
      idle_reg <= '0;
    end else if (!idle_done) begin
      idle_reg <= idle_reg + IW'(1);
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      data_hi_reg   <= 1'b0;
      stop_seen_reg <= 1'b0;
    end else begin
      data_hi_reg <= data_hi;
      if (state_reg != HSC_ST_ARMED) begin
        stop_seen_reg <= 1'b0;
      end else if (clock_hi && data_hi && !data_hi_reg) begin
        stop_seen_reg <= 1'b1;
      end else if (clock_hi && !data_hi && data_hi_reg) begin
        stop_seen_reg <= 1'b0;
      end
    end
  end

  // drops in the very cycle the loss of enable or termination is registered
  assign conn_ok = (state_reg == HSC_ST_CONNECTED) && (state_next == HSC_ST_CONNECTED);

  // channel 0 is clock, channel 1 is data
  always_ff @(posedge i_clock) begin
    for (int ch = 0; ch < 2; ch++) begin
      if (i_srst || !conn_ok) begin
        dir_reg[ch] <= HSC_DIR_IDLE;
      end else begin
        unique case (dir_reg[ch])
          HSC_DIR_IDLE: begin
            if (!se_hi[ch]) begin
              dir_reg[ch] <= HSC_DIR_TO_DIFF;
            end else if (diff_rev[ch]) begin
              dir_reg[ch] <= HSC_DIR_TO_SE;
            end
          end
          HSC_DIR_TO_DIFF: begin
            if (se_hi[ch]) begin
              dir_reg[ch] <= HSC_DIR_RELEASE;
            end
          end
          HSC_DIR_TO_SE: begin
            if (!diff_rev[ch]) begin
              dir_reg[ch] <= HSC_DIR_RELEASE;
            end
          end
          // our own drive echoes back through the synchroniser; waiting for
          // both sides to read released stops the channel latching itself
          HSC_DIR_RELEASE: begin
            if (se_hi[ch] && !diff_rev[ch]) begin
              dir_reg[ch] <= HSC_DIR_IDLE;
            end
          end
        endcase
      end
    end
  end

  // open-drain style outputs: drive value is fixed, only enables move
  always_ff @(posedge i_clock) begin
    if (i_srst || !conn_ok) begin
      o_scl              <= '{out: 1'b0, oe: 1'b0};
      o_sda              <= '{out: 1'b0, oe: 1'b0};
      o_diff_clock_plus  <= '{out: 1'b0, oe: 1'b0};
      o_diff_clock_minus <= '{out: 1'b1, oe: 1'b0};
      o_diff_data_plus   <= '{out: 1'b0, oe: 1'b0};
      o_diff_data_minus  <= '{out: 1'b1, oe: 1'b0};
    end else begin
      o_scl              <= '{out: 1'b0, oe: dir_reg[0] == HSC_DIR_TO_SE};
      o_sda              <= '{out: 1'b0, oe: dir_reg[1] == HSC_DIR_TO_SE};
      o_diff_clock_plus  <= '{out: 1'b0, oe: dir_reg[0] == HSC_DIR_TO_DIFF};
      o_diff_clock_minus <= '{out: 1'b1, oe: dir_reg[0] == HSC_DIR_TO_DIFF};
      o_diff_data_plus   <= '{out: 1'b0, oe: dir_reg[1] == HSC_DIR_TO_DIFF};
      o_diff_data_minus  <= '{out: 1'b1, oe: dir_reg[1] == HSC_DIR_TO_DIFF};
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_armed     <= 1'b0;
      o_connected <= 1'b0;
    end else begin
      o_armed     <= (state_next == HSC_ST_ARMED) || (state_next == HSC_ST_CONNECTED);
      o_connected <= (state_next == HSC_ST_CONNECTED);
    end
  end

endmodule : hsc_connect_ctrl

// file: rtl/hsc_defs.svh
/*
  timing and reset constants for the hot-swap bus connect controller.
  assumes a 40 MHz system clock; counts are derived from the printed times.
*/
`ifndef HSC_DEFS_SVH
`define HSC_DEFS_SVH

`define HSC_CLOCK_KHZ       40000
`define HSC_SETTLE_TIME_US  1000
`define HSC_ARM_TIME_US     10000
`define HSC_IDLE_TIME_US    50
// least times round up to whole cycles
`define HSC_SETTLE_CYCLES   ((`HSC_SETTLE_TIME_US * `HSC_CLOCK_KHZ + 999) / 1000)
`define HSC_ARM_CYCLES      ((`HSC_ARM_TIME_US * `HSC_CLOCK_KHZ + 999) / 1000)
`define HSC_IDLE_CYCLES     ((`HSC_IDLE_TIME_US * `HSC_CLOCK_KHZ + 999) / 1000)
`define HSC_TIMER_WIDTH     19
`define HSC_IDLE_WIDTH      19
`define HSC_SYNC_WIDTH      13
`define HSC_SYNC_RESET      13'h0000
`define HSC_TIMER_RESET     19'h00000

`endif

// file: rtl/hsc_pkg.sv
/*
  types for the hot-swap bus connect controller.
  assumes hsc_defs.svh supplies all numeric constants.
*/
package hsc_pkg;

  typedef enum logic [2:0] {
    HSC_ST_OFF,
    HSC_ST_SETTLE,
    HSC_ST_TERM_CHECK,
    HSC_ST_ARM_WAIT,
    HSC_ST_ARMED,
    HSC_ST_CONNECTED
  } hsc_state_t;

  typedef enum logic [1:0] {
    HSC_DIR_IDLE,
    HSC_DIR_TO_DIFF,
    HSC_DIR_TO_SE,
    HSC_DIR_RELEASE
  } hsc_dir_t;

  typedef struct packed {
    logic plus;
    logic minus;
  } hsc_diff_pair_t;

  typedef struct packed {
    logic out;
    logic oe;
  } hsc_pin_drive_t;

endpackage : hsc_pkg

// file: rtl/hsc_sync.sv
/*
  two-flop synchroniser for a vector of asynchronous levels.
  assumes each bit is an independent level; no word coherence.
*/
`timescale 1ns/1ps
`include "hsc_defs.svh"

module hsc_sync #(
  parameter int WIDTH = `HSC_SYNC_WIDTH
) (
  input  wire logic             i_clock,
  input  wire logic             i_srst,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      meta_reg <= '0;
      o_sync   <= '0;
    end else begin
      meta_reg <= i_async;
      o_sync   <= meta_reg;
    end
  end

endmodule : hsc_sync

// file: tb/hsc_props.sv
/*
  concurrent checks on the connect sequencer, bound into hsc_connect_ctrl.
  assumes it sees only the top module's ports and one clock domain.
*/
`timescale 1ns/1ps

module hsc_props
  import hsc_pkg::*;
#(
  parameter int SETTLE_CYCLES = 20,
  parameter int ARM_CYCLES    = 40
) (
  input wire logic           i_clock,
  input wire logic           i_srst,
  input wire logic           i_power_good,
  input wire logic           i_enable_level,
  input wire logic           i_enable_driven,
  input wire logic [1:0]     i_minus_below_hi,
  input wire hsc_pin_drive_t o_scl,
  input wire hsc_pin_drive_t o_sda,
  input wire hsc_pin_drive_t o_diff_clock_plus,
  input wire hsc_pin_drive_t o_diff_clock_minus,
  input wire hsc_pin_drive_t o_diff_data_plus,
  input wire hsc_pin_drive_t o_diff_data_minus,
  input wire logic           o_armed,
  input wire logic           o_connected
);
  logic [5:0]  oe;
  logic [19:0] pg_cnt_reg;
  assign oe = {o_scl.oe, o_sda.oe, o_diff_clock_plus.oe, o_diff_clock_minus.oe,
               o_diff_data_plus.oe, o_diff_data_minus.oe};
  // saturates so a long stable supply cannot wrap back below the limit
  always_ff @(posedge i_clock) begin
    if (i_srst || !i_power_good) pg_cnt_reg <= 20'h00000;
    else if (!(&pg_cnt_reg)) pg_cnt_reg <= pg_cnt_reg + 20'h00001;
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_srst);
  property p_reset_quiet; $fell(i_srst) |-> oe == 6'h00 && !o_armed; endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("pins driven after reset");
  property p_settle; $rose(o_armed) |-> pg_cnt_reg >= SETTLE_CYCLES + ARM_CYCLES; endproperty
  a_settle: assert property (p_settle) else $error("armed before both timers ran");
  property p_unjoined; !o_connected |-> oe == 6'h00; endproperty
  a_unjoined: assert property (p_unjoined) else $error("pin driven while unjoined");
  property p_join_armed; o_connected |-> o_armed; endproperty
  a_join_armed: assert property (p_join_armed) else $error("joined without arming");
  property p_en_low; (i_enable_driven && !i_enable_level) [*5] |-> !o_connected; endproperty
  a_en_low: assert property (p_en_low) else $error("joined with enable low");
  property p_pwr_loss; (!i_power_good) [*5] |-> !o_armed && !o_connected; endproperty
  a_pwr_loss: assert property (p_pwr_loss) else $error("still armed without power");
  property p_term_loss; (i_minus_below_hi != 2'h3) [*5] |-> !o_armed; endproperty
  a_term_loss: assert property (p_term_loss) else $error("armed without termination");
  property p_one_way;
    !(o_sda.oe && o_diff_data_plus.oe) && !(o_scl.oe && o_diff_clock_plus.oe);
  endproperty
  a_one_way: assert property (p_one_way) else $error("channel drives both sides");
  property p_pair_whole;
    o_diff_data_plus.oe == o_diff_data_minus.oe && o_diff_clock_plus.oe == o_diff_clock_minus.oe;
  endproperty
  a_pair_whole: assert property (p_pair_whole) else $error("pair half driven");
endmodule : hsc_props

bind hsc_connect_ctrl hsc_props #(.SETTLE_CYCLES(SETTLE_CYCLES), .ARM_CYCLES(ARM_CYCLES)) u_props (
  .i_clock(i_clock), .i_srst(i_srst), .i_power_good(i_power_good),
  .i_enable_level(i_enable_level), .i_enable_driven(i_enable_driven),
  .i_minus_below_hi(i_minus_below_hi), .o_scl(o_scl), .o_sda(o_sda),
  .o_diff_clock_plus(o_diff_clock_plus), .o_diff_clock_minus(o_diff_clock_minus),
  .o_diff_data_plus(o_diff_data_plus), .o_diff_data_minus(o_diff_data_minus),
  .o_armed(o_armed), .o_connected(o_connected));

// file: tb/hsc_far_bus.sv
/*
  far side of the differential pairs: bias network and one remote node.
  assumes the bench commands remote drive and termination presence.
*/
`timescale 1ns/1ps

module hsc_far_bus
  import hsc_pkg::*;
(
  input  wire logic       i_local_clk_oe,
  input  wire logic       i_local_dat_oe,
  input  wire logic [1:0] i_remote_drive,
  input  wire logic       i_term_on,
  output hsc_diff_pair_t  o_diff_clock,
  output hsc_diff_pair_t  o_diff_data,
  output logic [1:0]      o_minus_below_hi,
  output logic [1:0]      o_plus_above_lo
);
  // released pair rests plus over minus; any driver reverses it (wired-or)
  assign o_diff_clock = (i_local_clk_oe || i_remote_drive[0]) ? 2'h1 : 2'h2;
  assign o_diff_data  = (i_local_dat_oe || i_remote_drive[1]) ? 2'h1 : 2'h2;
  // no termination means no bias: both comparators drop together
  assign o_minus_below_hi = {2{i_term_on}};
  assign o_plus_above_lo  = {2{i_term_on}};
endmodule : hsc_far_bus

// file: tb/hot_swap_bus_connect_control_tb.sv
/*
  self-checking bench for hsc_connect_ctrl with the far bus model.
  assumes shortened timers; inputs change on falling clock edges.
*/
`timescale 1ns/1ps

module hot_swap_bus_connect_control_tb;
  import hsc_pkg::*;
  localparam int SET = 20;
  localparam int ARM = 40;
  localparam int IDL = 10;
  logic           clk = 0, srst = 1, pg = 0, en = 1, en_drv = 1, term = 1;
  logic [1:0]     se_low = 0, rem = 2'h2, mb, pa;
  logic           scl, sda, armed, conn;
  hsc_diff_pair_t dc, dd;
  hsc_pin_drive_t q_scl, q_sda, q_cp, q_cm, q_dp, q_dm;
  int             errors = 0, comparisons = 0;
  always #12.5 clk = ~clk;
  // open-drain lines with pull-ups
  assign scl = !(q_scl.oe || se_low[0]);
  assign sda = !(q_sda.oe || se_low[1]);
  hsc_connect_ctrl #(.SETTLE_CYCLES(SET), .ARM_CYCLES(ARM), .IDLE_CYCLES(IDL)) u_dut (
    .i_clock(clk), .i_srst(srst), .i_power_good(pg), .i_enable_level(en),
    .i_enable_driven(en_drv), .i_scl(scl), .i_sda(sda), .i_diff_clock(dc),
    .i_diff_data(dd), .i_minus_below_hi(mb), .i_plus_above_lo(pa), .o_scl(q_scl),
    .o_sda(q_sda), .o_diff_clock_plus(q_cp), .o_diff_clock_minus(q_cm),
    .o_diff_data_plus(q_dp), .o_diff_data_minus(q_dm), .o_armed(armed), .o_connected(conn));
  hsc_far_bus u_far (.i_local_clk_oe(q_cp.oe), .i_local_dat_oe(q_dp.oe), .i_remote_drive(rem),
    .i_term_on(term), .o_diff_clock(dc), .o_diff_data(dd), .o_minus_below_hi(mb),
    .o_plus_above_lo(pa));
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic report(input logic [5:0] got, input logic [5:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : report
  task automatic chk_bit(input logic got, input logic exp);
    report({5'h00, got}, {5'h00, exp});
  endtask : chk_bit
  // drive values never move: plus sinks low, minus sources high, so a driven pair reads reversed
  task automatic chk_oe(input logic [5:0] exp);
    report({q_scl.oe, q_sda.oe, q_cp.oe, q_cm.oe, q_dp.oe, q_dm.oe}, exp);
    report({q_scl.out, q_sda.out, q_cp.out, q_cm.out, q_dp.out, q_dm.out}, 6'h05);
  endtask : chk_oe
  // a low single-ended line wins over a reversed pair seen together
  function automatic logic [5:0] exp_oe(input logic [1:0] s, input logic [1:0] r);
    exp_oe = {r[0] & ~s[0], r[1] & ~s[1], s[0], s[0], s[1], s[1]};
  endfunction : exp_oe
  task automatic end_sim;
    if (errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim
  initial begin
    cyc(6000);
    errors++;
    end_sim;
  end
  initial begin
    void'($urandom(24852));
    cyc(16);
    srst = 0;
    term = 0;
    cyc(3);
    chk_oe(6'h00);
    pg = 1;
    cyc(100);
    chk_bit(armed, 1'b0);
    term = 1;
    cyc(ARM - 5);
    chk_bit(armed, 1'b0);
    cyc(15);
    chk_bit(armed, 1'b1);
    chk_bit(conn, 1'b0);
    // stop seen while the local clock is held low must not join
    se_low = 2'h1;
    rem = 2'h0;
    cyc(6);
    chk_bit(conn, 1'b0);
    // a start afterwards forgets that stop
    rem = 2'h2;
    cyc(6);
    se_low = 2'h0;
    cyc(6);
    chk_bit(conn, 1'b0);
    rem = 2'h0;
    cyc(6);
    chk_bit(conn, 1'b1);
    for (int i = 0; i < 40; i++) begin
      se_low = (i == 0) ? 2'h3 : 2'($urandom_range(3, 0));
      rem = (i == 0) ? 2'h3 : 2'($urandom_range(3, 0));
      cyc(8);
      chk_oe(exp_oe(se_low, rem));
      se_low = 2'h0;
      rem = 2'h0;
      cyc(8);
      chk_oe(6'h00);
    end
    // enable only moves while both sides are idle
    en = 0;
    cyc(6);
    chk_bit(conn, 1'b0);
    chk_oe(6'h00);
    en_drv = 0;
    cyc(1);
    rem = 2'h1;
    cyc(ARM + 29);
    chk_bit(conn, 1'b0);
    rem = 2'h0;
    cyc(6);
    chk_bit(conn, 1'b0);
    cyc(IDL + 6);
    chk_bit(conn, 1'b1);
    // termination lost while the clock channel is driving
    se_low = 2'h1;
    cyc(8);
    chk_oe(exp_oe(se_low, 2'h0));
    term = 0;
    cyc(6);
    chk_bit(conn, 1'b0);
    chk_bit(armed, 1'b0);
    chk_oe(6'h00);
    se_low = 2'h0;
    term = 1;
    cyc(ARM + IDL + 10);
    chk_bit(conn, 1'b1);
    pg = 0;
    cyc(6);
    chk_bit(armed, 1'b0);
    pg = 1;
    cyc(SET + ARM - 5);
    chk_bit(armed, 1'b0);
    cyc(20);
    chk_bit(armed, 1'b1);
    end_sim;
  end
endmodule : hot_swap_bus_connect_control_tb
